// [scu_params.svh]
/*
  Constants of the smart-card UART configuration block: register indices,
  field positions, reset values and ETU counts.
  Assumes it is included by bare name by the package and design modules.
*/
`ifndef SCU_PARAMS_SVH
`define SCU_PARAMS_SVH
// Register indices; byte address is four times the index.
`define SCU_IDX_DATA 4'h0
`define SCU_IDX_CLK 4'h1
`define SCU_IDX_DIV 4'h2
`define SCU_IDX_SET2 4'h3
`define SCU_IDX_GUARD 4'h5
`define SCU_IDX_SET1 4'h6
`define SCU_IDX_STATE 4'h8
`define SCU_IDX_IRQ 4'h9
`define SCU_IDX_MASK 4'ha
// Field positions of uart_setup_one.
`define SCU_S1_FBP 6
`define SCU_S1_DIR 3
`define SCU_S1_FIN 2
`define SCU_S1_WATCH 1
`define SCU_S1_DCF 0
`define SCU_S1_T1 4
// Field positions of uart_setup_two and card_clock_setup.
`define SCU_S2_MAN 2
`define SCU_S2_DBL 1
`define SCU_S2_PSC 0
`define SCU_CK_HIGH 5
`define SCU_CK_HALT 4
// Reset values and counts.
`define SCU_RST8 8'h00
`define SCU_PRESC_LO 6'h1f
`define SCU_PRESC_HI 6'h20
`define SCU_GUARD_SPECIAL 8'hff
`define SCU_GUARD_T1 8'h01
`define SCU_GUARD_T0 8'h02
`define SCU_LAST_BIT 4'h9
`define SCU_HALF_NAK 4'ha
`define SCU_HALF_END 4'hb
`define SCU_TS_DIRECT 8'h3b
`define SCU_TS_INVERSE 8'h03
`endif

// [scu_pkg.sv]
/*
  Types of the smart-card UART configuration block.
  Assumes scu_params.svh is on the include path.
*/
`default_nettype none
`include "scu_params.svh"
package scu_pkg;
    typedef enum logic [1:0] {scu_idle, scu_tx, scu_guard, scu_rx} scu_mode_e;
    // Card clock generator state.
    typedef struct packed {
        logic [2:0] cnt;
        logic clk;
        logic rise;
        logic fall;
    } scu_ck_s;
    // ETU generator state.
    typedef struct packed {
        logic [13:0] cnt;
        logic tick;
        logic half;
    } scu_etu_s;
    // Main block state.
    typedef struct packed {
        logic [5:0] clk_set;
        logic [7:0] div;
        logic [2:0] set2;
        logic [7:0] guard;
        logic [6:0] set1;
        logic [7:0] tx_hold;
        logic tx_full;
        logic slot_free;
        logic [7:0] rx_data;
        logic rx_full;
        logic [3:0] irq_st;
        logic [3:0] irq_mask;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        scu_mode_e mode;
        logic [3:0] bitn;
        logic [8:0] sh;
        logic [7:0] gleft;
        logic nak;
        logic io_oe;
        logic io_out;
    } scu_state_s;
endpackage
`default_nettype wire

// [scu_card_clk.sv]
/*
  Card clock generator with glitch-free stop.
  Assumes select and halt come from registers in the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scu_params.svh"
module scu_card_clk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic [2:0] sel,
    input wire logic halt,
    input wire logic halt_high,
    // Card clock and its edge pulses
    output logic card_clk,
    output logic rise,
    output logic fall
);
    scu_pkg::scu_ck_s s, n;
    logic [2:0] lim;
    logic tgl;

    // Toggle period in pclk cycles: 1, 2, 4, 8 from the crystal, 2 from the oscillator.
    // divider codes
    assign lim = sel[2] ? 3'h1 : 3'((4'h1 << sel[1:0]) - 4'h1);

    // Toggling stops only once the line sits at the halt level, so no short pulse escapes.
    // stop level
    always_comb
    begin
        n = s;
        tgl = (s.cnt >= lim) && !(halt && (s.clk == halt_high));
        n.cnt = (s.cnt >= lim) ? 3'h0 : s.cnt + 3'h1;
        n.clk = s.clk ^ tgl;
        n.rise = tgl && !s.clk;
        n.fall = tgl && s.clk;
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s <= '0;
        else
            s <= n;
    end

    assign card_clk = s.clk;
    assign rise = s.rise;
    assign fall = s.fall;
endmodule
`default_nettype wire

// [scu_etu_gen.sv]
/*
  Elementary time unit generator counting card clock edges.
  Assumes edge pulses are one pclk cycle wide.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scu_params.svh"
module scu_etu_gen (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Card clock edges
    input wire logic rise,
    input wire logic fall,
    // Setup
    input wire logic psc_hi,
    input wire logic dbl,
    input wire logic [7:0] div,
    input wire logic restart,
    // Ticks at each ETU boundary and at mid-ETU
    output logic tick,
    output logic half
);
    scu_pkg::scu_etu_s s, n;
    logic [13:0] len;
    logic en;

    assign len = 14'(psc_hi ? `SCU_PRESC_HI : `SCU_PRESC_LO) * 14'(div);
    assign en = rise | (dbl & fall);

    // Down counter that reloads at zero; restart realigns it to a line edge.
    // auto-reload count
    always_comb
    begin
        n = s;
        n.tick = 1'b0;
        n.half = 1'b0;
        if (restart)
            n.cnt = (len == 14'h0) ? 14'h0 : len - 14'h1;
        else if (en)
        begin
            n.half = (s.cnt == (len >> 1));
            if (s.cnt == 14'h0)
            begin
                n.tick = 1'b1;
                n.cnt = (len == 14'h0) ? 14'h0 : len - 14'h1;
            end
            else
                n.cnt = s.cnt - 14'h1;
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s <= '0;
        else
            s <= n;
    end

    assign tick = s.tick;
    assign half = s.half;
endmodule
`default_nettype wire

// [scu_uart_cfg.sv]
/*
  Smart-card UART core with its configuration registers on APB.
  Assumes the card I/O line is open drain with an outside pull-up and that
  io_in is synchronous to pclk. Half duplex: one character at a time.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scu_params.svh"
module scu_uart_cfg (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Card side
    input wire logic io_in,
    output logic io_out,
    output logic io_oe,
    output logic card_clk,
    // Interrupt
    output logic irq
);
    scu_pkg::scu_state_s s, n;
    logic ck_rise;
    logic ck_fall;
    logic etu_tick;
    logic etu_half;
    logic etu_restart;

    // Bit order and polarity swap between the line and the byte; it is its own inverse.
    function automatic logic [7:0] code_map(input logic [7:0] v, input logic direct);
        logic [7:0] r;
        for (int i = 0; i < 8; i++)
            r[i] = v[7 - i];
        return direct ? v : ~r;
    endfunction

    // Parity bit as it appears on the line for a line-order byte.
    function automatic logic line_par(input logic [7:0] r, input logic direct);
        return direct ? ^r : ~^r;
    endfunction

    // Card clock source.
    scu_card_clk u_clk (
        .pclk(pclk),
        .presetn(presetn),
        .sel(s.clk_set[2:0]),
        .halt(s.clk_set[`SCU_CK_HALT]),
        .halt_high(s.clk_set[`SCU_CK_HIGH]),
        .card_clk(card_clk),
        .rise(ck_rise),
        .fall(ck_fall)
    );

    // ETU timing source.
    scu_etu_gen u_etu (
        .pclk(pclk),
        .presetn(presetn),
        .rise(ck_rise),
        .fall(ck_fall),
        .psc_hi(s.set2[`SCU_S2_PSC]),
        .dbl(s.set2[`SCU_S2_DBL]),
        .div(s.div),
        .restart(etu_restart),
        .tick(etu_tick),
        .half(etu_half)
    );

    // Bus access first, line engine second, so hardware events win over software clears.
    always_comb
    begin
        logic [3:0] idx;
        logic setup;
        logic acc;
        logic hit;
        logic [7:0] rd;
        logic [7:0] r;
        logic ev_slot;
        logic ev_rx;
        logic ev_err;
        logic ev_ovr;
        logic cd;
        logic bad;
        logic nakit;
        idx = paddr[5:2];
        setup = psel && !penable;
        acc = psel && penable && s.pready;
        hit = 1'b0;
        rd = `SCU_RST8;
        r = `SCU_RST8;
        ev_slot = 1'b0;
        ev_rx = 1'b0;
        ev_err = 1'b0;
        ev_ovr = 1'b0;
        cd = s.set1[`SCU_S1_DCF];
        bad = 1'b0;
        nakit = 1'b0;
        etu_restart = 1'b0;
        n = s;

        // Read mux and decode; high address bits outside the map are unmapped.
        // register map
        case (idx)
            `SCU_IDX_DATA:
            begin
                hit = 1'b1;
                rd = s.rx_data;
            end
            `SCU_IDX_CLK:
            begin
                hit = 1'b1;
                rd = {2'h0, s.clk_set};
            end
            `SCU_IDX_DIV:
            begin
                hit = 1'b1;
                rd = s.div;
            end
            `SCU_IDX_SET2:
            begin
                hit = 1'b1;
                rd = {5'h00, s.set2};
            end
            `SCU_IDX_GUARD:
            begin
                hit = 1'b1;
                rd = s.guard;
            end
            `SCU_IDX_SET1:
            begin
                hit = 1'b1;
                rd = {1'b0, s.set1};
            end
            `SCU_IDX_STATE:
            begin
                hit = 1'b1;
                rd = {5'h00, s.mode != scu_pkg::scu_idle,
                      s.set1[`SCU_S1_DIR] ? s.slot_free : s.rx_full, s.rx_full};
            end
            `SCU_IDX_IRQ:
            begin
                hit = 1'b1;
                rd = {4'h0, s.irq_st};
            end
            `SCU_IDX_MASK:
            begin
                hit = 1'b1;
                rd = {4'h0, s.irq_mask};
            end
            default:
                hit = 1'b0;
        endcase
        hit = hit && (paddr[7:6] == 2'h0);

        // Answer is prepared in the setup cycle so pready and prdata come from flops.
        n.pready = setup;
        n.pslverr = setup && !hit;
        n.prdata = setup ? {24'h000000, hit ? rd : `SCU_RST8} : s.prdata;

        // Register writes and read side effects at the completing access edge.
        if (acc && hit && pwrite)
        begin
            case (idx)
                `SCU_IDX_DATA:
                begin
                    n.tx_hold = pwdata[7:0];
                    n.tx_full = 1'b1;
                    n.slot_free = 1'b0;
                end
                `SCU_IDX_CLK:
                    n.clk_set = pwdata[5:0];
                `SCU_IDX_DIV:
                    n.div = pwdata[7:0];
                `SCU_IDX_SET2:
                    n.set2 = pwdata[2:0];
                `SCU_IDX_GUARD:
                    n.guard = pwdata[7:0];
                `SCU_IDX_SET1:
                begin
                    n.set1 = pwdata[6:0];
                    if (pwdata[`SCU_S1_DIR] && !s.set1[`SCU_S1_DIR])
                    begin
                        n.slot_free = 1'b1;
                        ev_slot = 1'b1;
                    end
                    else if (!pwdata[`SCU_S1_DIR])
                        n.slot_free = 1'b0;
                    if (!s.set2[`SCU_S2_MAN])
                        n.set1[`SCU_S1_DCF] = s.set1[`SCU_S1_DCF];
                end
                `SCU_IDX_MASK:
                    n.irq_mask = pwdata[3:0];
                default:
                    n.irq_mask = s.irq_mask;
            endcase
        end
        if (acc && hit && !pwrite && idx == `SCU_IDX_DATA)
            n.rx_full = 1'b0;

        // Line engine: transmit, guard wait and receive share one sequencer.
        case (s.mode)
            scu_pkg::scu_idle:
            begin
                n.io_oe = 1'b0;
                if (s.set1[`SCU_S1_DIR] && s.tx_full)
                begin
                    r = code_map(s.tx_hold, cd);
                    n.sh = {line_par(r, cd) ^ s.set1[`SCU_S1_FBP], r};
                    n.io_oe = 1'b1;
                    n.bitn = 4'h0;
                    n.tx_full = 1'b0;
                    n.slot_free = 1'b1;
                    ev_slot = 1'b1;
                    etu_restart = 1'b1;
                    n.mode = scu_pkg::scu_tx;
                end
                else if (!s.set1[`SCU_S1_DIR] && !io_in)
                begin
                    n.bitn = 4'h0;
                    etu_restart = 1'b1;
                    n.mode = scu_pkg::scu_rx;
                end
            end
            scu_pkg::scu_tx:
            begin
                if (etu_tick)
                begin
                    n.io_oe = !s.sh[0];
                    n.sh = {1'b1, s.sh[8:1]};
                    n.bitn = s.bitn + 4'h1;
                    if (s.bitn == `SCU_LAST_BIT)
                    begin
                        n.io_oe = 1'b0;
                        n.nak = 1'b0;
                        n.bitn = `SCU_HALF_NAK;
                        if (s.guard == `SCU_GUARD_SPECIAL)
                            n.gleft = s.set1[`SCU_S1_T1] ? `SCU_GUARD_T1 : `SCU_GUARD_T0;
                        else
                            n.gleft = s.guard;
                        n.mode = scu_pkg::scu_guard;
                    end
                end
            end
            scu_pkg::scu_guard:
            begin
                if (etu_half && s.bitn == `SCU_HALF_NAK)
                begin
                    n.bitn = `SCU_HALF_END;
                    n.nak = !s.set1[`SCU_S1_T1] && !io_in;
                end
                if (etu_tick)
                begin
                    if (s.gleft <= 8'h01)
                    begin
                        n.mode = scu_pkg::scu_idle;
                        ev_err = s.nak;
                        if (!s.nak && s.set1[`SCU_S1_FIN] && !n.tx_full)
                        begin
                            n.set1[`SCU_S1_FIN] = 1'b0;
                            n.set1[`SCU_S1_DIR] = 1'b0;
                            n.slot_free = 1'b0;
                        end
                    end
                    else
                        n.gleft = s.gleft - 8'h01;
                end
            end
            scu_pkg::scu_rx:
            begin
                if (etu_half)
                begin
                    n.bitn = s.bitn + 4'h1;
                    if (s.bitn == 4'h0)
                    begin
                        // A start bit gone high at mid-bit was a glitch.
                        if (io_in)
                            n.mode = scu_pkg::scu_idle;
                    end
                    else if (s.bitn < `SCU_LAST_BIT)
                        n.sh[7:0] = {io_in, s.sh[7:1]};
                    else if (s.bitn == `SCU_LAST_BIT)
                    begin
                        if (s.set1[`SCU_S1_WATCH] && !s.set2[`SCU_S2_MAN])
                        begin
                            if (s.sh[7:0] == `SCU_TS_DIRECT)
                                cd = 1'b1;
                            else if (s.sh[7:0] == `SCU_TS_INVERSE)
                                cd = 1'b0;
                            n.set1[`SCU_S1_DCF] = cd;
                        end
                        bad = io_in != line_par(s.sh[7:0], cd);
                        nakit = bad ^ s.set1[`SCU_S1_FBP];
                        n.nak = nakit && !s.set1[`SCU_S1_T1];
                        ev_err = bad;
                        if (!nakit)
                        begin
                            ev_rx = 1'b1;
                            ev_ovr = n.rx_full;
                            if (!n.rx_full)
                            begin
                                n.rx_data = code_map(s.sh[7:0], cd);
                                n.rx_full = 1'b1;
                            end
                        end
                    end
                    else if (s.bitn == `SCU_HALF_NAK)
                    begin
                        n.set1[`SCU_S1_WATCH] = 1'b0;
                        n.io_oe = s.nak;
                        if (!s.nak)
                            n.mode = scu_pkg::scu_idle;
                    end
                    else
                    begin
                        n.io_oe = 1'b0;
                        n.mode = scu_pkg::scu_idle;
                    end
                end
            end
            default:
                n.mode = scu_pkg::scu_idle;
        endcase

        // Sticky events; a set in the clearing read cycle survives.
        if (acc && hit && !pwrite && idx == `SCU_IDX_IRQ)
            n.irq_st = 4'h0;
        n.irq_st = n.irq_st | {ev_ovr, ev_err, ev_rx, ev_slot};
        n.irq = |(n.irq_st & n.irq_mask);
        n.io_out = 1'b0;
    end

    // State register; every control bit resets to zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s <= '0;
        else
            s <= n;
    end

    // Outputs straight from the state register.
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign io_out = s.io_out;
    assign io_oe = s.io_oe;
    assign irq = s.irq;
endmodule
`default_nettype wire

// [scu_uart_cfg_properties.sv]
/*
  Checker of scu_uart_cfg: APB answer timing, register readback and card clock.
  Assumes a bind to the top module; it sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module scu_uart_cfg_properties (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Card side
    input wire logic card_clk
);
    logic [7:0] guard_reg;
    logic [5:0] ck_reg;
    logic [5:0] calm_reg;
    logic wr_ok;
    assign wr_ok = psel && penable && pready && pwrite && paddr[7:6] == 2'b00;
    // Shadows of two registers; calm_reg counts cycles since the clock setup
    // was written, because the glitch-free switch settles only later.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            guard_reg <= 8'h00;
            ck_reg <= 6'h00;
            calm_reg <= 6'h00;
        end
        else
        begin
            if (wr_ok && paddr[5:2] == 4'h5)
                guard_reg <= pwdata[7:0];
            if (wr_ok && paddr[5:2] == 4'h1)
                ck_reg <= pwdata[5:0];
            calm_reg <= (wr_ok && paddr[5:2] == 4'h1) ? 6'h00 : calm_reg + 6'(calm_reg != 6'h3f);
        end
    end
    // All properties share the bus clock and its reset.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    ready_next_a: assert property (psel && !penable |=> pready)
        else $error("no answer in the first access cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (psel && !penable && paddr[5:2] == 4'h4 |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    high_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    guard_back_a: assert property (psel && penable && pready && !pwrite && paddr[5:2] == 4'h5 |-> prdata[7:0] == guard_reg)
        else $error("guard interval readback wrong");
    halt_level_a: assert property (calm_reg == 6'h3f && ck_reg[4] |-> card_clk == ck_reg[5])
        else $error("stopped card clock at wrong level");
    fast_clock_a: assert property (calm_reg == 6'h3f && !ck_reg[4] && ck_reg[2:0] == 3'h0 |=> card_clk != $past(card_clk))
        else $error("card clock not toggling every cycle");
endmodule
bind scu_uart_cfg scu_uart_cfg_properties u_scu_uart_cfg_properties (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .card_clk(card_clk));
`default_nettype wire

// [scu_card_model.sv]
/*
  Behavioural smart card on the open-drain I/O line, direct convention.
  Assumes an ETU of 31 card clock rises and a pulled-up line.
*/
`timescale 1ns/1ps
`default_nettype none
module scu_card_model (
    // Card clock and line
    input wire logic card_clk,
    input wire logic io,
    // Pull of the line towards low
    output logic pull_low
);
    logic [8:0] got;
    int got_n = 0;
    time start_t;
    logic sending = 1'b0;
    initial pull_low = 1'b0;
    // One frame: start bit, data LSB first, even parity; it never NAKs.
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {^b, b, 1'b0};
        sending = 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            pull_low <= !f[i];
            repeat (31) @(posedge card_clk);
        end
        pull_low <= 1'b0;
        // Deaf over the answer window so a NAK from the reader is not captured as a frame.
        repeat (62) @(posedge card_clk);
        sending = 1'b0;
    endtask
    // Capture a frame from the reader, sampling each bit at its middle.
    always @(negedge io)
    begin
        if (!sending)
        begin
            start_t = $time;
            repeat (15) @(posedge card_clk);
            for (int i = 0; i < 9; i++)
            begin
                repeat (31) @(posedge card_clk);
                got = {io, got[8:1]};
            end
            got_n++;
        end
    end
endmodule
`default_nettype wire

// [scu_uart_cfg_tb_top.sv]
/*
  Self-checking bench of scu_uart_cfg: setup registers over APB, card clock
  codes, reception of the initial character, transmit spacing and interrupts.
  Assumes the card model and the checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module scu_uart_cfg_tb_top;
    // One ETU is 31 card clock rises of two pclk cycles each at code 000.
    localparam int ETU_CYC = 62;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, io_out, io_oe, card_clk, irq, pull_low, er, prev;
    logic [7:0] v, g, d0, d1;
    logic [7:0] gv [4] = '{8'h00, 8'hff, 8'hff, 8'h03};
    logic [7:0] mk [4] = '{8'hff, 8'h3f, 8'h50, 8'h07};
    logic [3:0] ridx [4] = '{4'h5, 4'h1, 4'h6, 4'h3};
    logic tv [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic fv [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    int fail_count = 0;
    int checks_done = 0;
    int n, n0;
    time t0, gap;
    wire io_line;
    // Open-drain line with a pull-up: low while either side pulls.
    assign io_line = !(io_oe || pull_low);
    always #2 pclk = ~pclk;
    scu_uart_cfg u_scu_uart_cfg (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .io_in(io_line), .io_out(io_out), .io_oe(io_oe),
        .card_clk(card_clk), .irq(irq));
    scu_card_model u_scu_card_model (.card_clk(card_clk), .io(io_line), .pull_low(pull_low));
    // Verdict and end of the run.
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // A wait that ran out counts as a mismatch and ends the run.
    task automatic hung();
        fail_count++;
        report_and_stop();
    endtask
    // Compare one value and count it.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("wrong value %s: expected %0h, seen %0h", what, exp, got);
            fail_count++;
        end
    endtask
    // Start-to-start spacing in ETU for a guard value and protocol.
    function automatic int spacing_etu(input logic [7:0] gt, input logic t1);
        return (gt == 8'hff) ? (t1 ? 11 : 12) : 10 + ((gt == 8'h00) ? 1 : gt);
    endfunction
    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic apb(input logic w, input logic [3:0] idx, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20)
            hung();
    endtask
    // Read a register until the masked bits are all clear.
    task automatic poll(input logic [3:0] idx, input logic [7:0] m);
        int k;
        for (k = 0; k < 400; k++)
        begin
            apb(1'b0, idx, 8'h00);
            if ((rd[7:0] & m) === 8'h00)
                break;
        end
        if (k == 400)
            hung();
    endtask
    // Wait until the card has captured a given number of frames.
    task automatic wait_card(input int cnt);
        int k;
        for (k = 0; k < 2000 && u_scu_card_model.got_n < cnt; k++)
            @(posedge pclk);
        if (k == 2000)
            hung();
    endtask
    // Main sequence.
    initial
    begin
        void'($urandom(32'h1a54201c));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, ridx[i], 8'h00);
            chk("reset value", 0, rd);
            v = 8'($urandom) & mk[i];
            apb(1'b1, ridx[i], v);
            apb(1'b0, ridx[i], 8'h00);
            chk("readback", v, rd);
        end
        apb(1'b1, 4'h4, 8'h5a);
        chk("unmapped error", 1, er);
        apb(1'b0, 4'h4, 8'h00);
        chk("unmapped data", 0, rd);
        // Codes 0 to 7 run the clock; 8 and 9 stop it low and high.
        for (int s = 0; s < 10; s++)
        begin
            apb(1'b1, 4'h1, (s > 7) ? 8'((s - 8) * 32 + 16) : 8'(s));
            repeat (70) @(posedge pclk);
            n = 0;
            prev = card_clk;
            repeat (64)
            begin
                @(posedge pclk);
                n += (card_clk !== prev);
                prev = card_clk;
            end
            if (s > 7)
                chk("halted level", s - 8, prev + n);
            else
                chk("clock toggles", (s > 3) ? 32 : 64 >> s, n);
        end
        apb(1'b1, 4'h1, 8'h00);
        apb(1'b1, 4'h2, 8'h01);
        apb(1'b1, 4'h3, 8'h00);
        apb(1'b1, 4'ha, 8'h02);
        apb(1'b1, 4'h6, 8'h02);
        u_scu_card_model.send(8'h3b);
        chk("irq raised", 1, irq);
        apb(1'b0, 4'h9, 8'h00);
        chk("irq status", 2, rd);
        repeat (3) @(posedge pclk);
        chk("irq cleared", 0, irq);
        apb(1'b0, 4'h6, 8'h00);
        chk("watch and convention", 1, rd);
        apb(1'b0, 4'h0, 8'h00);
        chk("received char", 8'h3b, rd);
        // Two back-to-back characters, then a final one once the line is idle.
        for (int c = 0; c < 4; c++)
        begin
            g = (c == 3) ? 8'($urandom_range(6, 1)) : gv[c];
            d0 = 8'($urandom);
            d1 = 8'($urandom);
            apb(1'b1, 4'h5, g);
            apb(1'b1, 4'h6, {1'b0, fv[c], 1'b0, tv[c], 4'b1001});
            apb(1'b0, 4'h8, 8'h00);
            chk("slot free", 1, rd[1]);
            n0 = u_scu_card_model.got_n;
            apb(1'b1, 4'h0, d0);
            wait_card(n0 + 1);
            t0 = u_scu_card_model.start_t;
            chk("sent char", {fv[c] ^ (^d0), d0}, u_scu_card_model.got);
            apb(1'b1, 4'h0, d1);
            wait_card(n0 + 2);
            gap = (u_scu_card_model.start_t - t0) / 4;
            n = spacing_etu(g, tv[c]);
            chk("char spacing", 1, gap + 31 - n * ETU_CYC <= 62);
            poll(4'h8, 8'h04);
            apb(1'b1, 4'h6, {1'b0, fv[c], 1'b0, tv[c], 4'b1101});
            apb(1'b1, 4'h0, d1);
            wait_card(n0 + 3);
            chk("final char", {fv[c] ^ (^d1), d1}, u_scu_card_model.got);
            poll(4'h6, 8'h0c);
            chk("back to receive", 0, rd & 8'h0c);
        end
        chk("irq masked", 0, irq);
        chk("io out", 0, io_out);
        report_and_stop();
    end
endmodule
`default_nettype wire
